// *** dv/pic_core_sva.sv ***
// Checker for pic_core: record timing on channel 0, gate lengths, reset quiet.
// Assumes in-range settings, stable from each trigger until its record.
module pic_core_sva
  import pic_pkg::*;
#(
  parameter int NCH = 2,
  parameter int SAMPLE_W = 14,
  parameter int WIN_MAX_CYC = 64
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [NCH-1:0][SAMPLE_W-1:0] sampleIn,
  input wire logic [NCH-1:0] thrCross,
  input wire pic_psa_cfg_s [NCH-1:0] psaCfg,
  input wire pic_win_cfg_s [NCH-1:0] winCfg,
  input wire logic [TIME_W-1:0] coincGateCyc,
  input wire logic [TIME_W-1:0] antiGateCyc,
  input wire pic_rec_s [NCH-1:0] pulseShapeIntegrals,
  input wire logic coincidenceOut,
  input wire logic anticoincidenceOut
);
  timeunit 1ns;
  timeprecision 1ps;
  int recCnt;
  int cHi;
  int aHi;
  // Longest window end decides when the record may appear
  function automatic int recLat(pic_psa_cfg_s c);
    int r = int'(c.riseLen) - int'(c.riseStart);
    int f = int'(c.fallStop) + 1;
    int t = int'(c.totalLen) - int'(c.totalStart);
    return (r > f) ? ((r > t) ? r : t) : ((f > t) ? f : t);
  endfunction
  // Busy model of channel 0 and run lengths of both gates
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      recCnt <= 0;
      cHi <= 0;
      aHi <= 0;
    end
    else
    begin
      if (thrCross[0] && recCnt <= 1)
        recCnt <= recLat(psaCfg[0]) + 1; // Retrigger while busy is ignored
      else if (recCnt != 0)
        recCnt <= recCnt - 1;
      cHi <= coincidenceOut ? cHi + 1 : 0;
      aHi <= anticoincidenceOut ? aHi + 1 : 0;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  property p_rec_time; recCnt == 1 |-> pulseShapeIntegrals[0].valid; endproperty
  a_rec_time: assert property (p_rec_time) else $error("record late");
  property p_rec_only; pulseShapeIntegrals[0].valid |-> recCnt == 1; endproperty
  a_rec_only: assert property (p_rec_only) else $error("record early");
  property p_valid_pulse; pulseShapeIntegrals[0].valid |=> !pulseShapeIntegrals[0].valid;
  endproperty
  a_valid_pulse: assert property (p_valid_pulse) else $error("valid too long");
  // Only the fields must hold; valid itself drops after its one cycle
  property p_fields_hold; !pulseShapeIntegrals[0].valid |->
    $stable({pulseShapeIntegrals[0].rise, pulseShapeIntegrals[0].fall,
      pulseShapeIntegrals[0].total});
  endproperty
  a_fields_hold: assert property (p_fields_hold) else $error("fields moved");
  // At the falling edge the sampled run counter already holds the full gate length
  property p_coinc_len; $fell(coincidenceOut) |-> cHi == int'(coincGateCyc); endproperty
  a_coinc_len: assert property (p_coinc_len) else $error("coinc gate length");
  property p_anti_len; $fell(anticoincidenceOut) |-> aHi == int'(antiGateCyc); endproperty
  a_anti_len: assert property (p_anti_len) else $error("anti gate length");
  property p_coinc_cause; $rose(coincidenceOut) |-> $past(|thrCross, 2); endproperty
  a_coinc_cause: assert property (p_coinc_cause) else $error("coinc uncaused");
  property p_rst_quiet; $fell(rst) |-> !coincidenceOut && !anticoincidenceOut; endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("output after reset");
endmodule

// *** dv/pic_wave_src.sv ***
// Waveform source: a ramp of one step per clock, wrapping at the sample width.
// Assumes the crossing is flagged at an absolute cycle chosen by the bench.
module pic_wave_src (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic negPol,
  input wire logic [31:0] trigAt,
  output logic [31:0] cnt,
  output logic [13:0] sample,
  output logic thr
);
  timeunit 1ns;
  timeprecision 1ps;
  // Sample value equals its cycle index, so any window sum is easy to predict
  always_ff @(posedge core_clk or posedge rst)
    cnt <= rst ? 32'h0 : cnt + 32'h1;
  assign sample = negPol ? ~cnt[13:0] : cnt[13:0]; // Negative detector flips the ramp
  assign thr = (cnt == trigAt);
endmodule

// *** dv/tb_top.sv ***
// Testbench for pic_core: window sums, scaling, coincidence and anticoincidence gates.
// Assumes pic_pkg, pic_core, pic_wave_src and pic_core_sva are compiled first.
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin mismatches++; \
  $display("unexpected %0t: %h vs %h", $time, a, b); end end
module tb_top import pic_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'h0;
  logic rst = 1'h1;
  logic negPol = 1'h0;
  logic [31:0] trig0 = 32'hFFFFFFFF;
  logic [31:0] trig1 = 32'hFFFFFFFF;
  logic [31:0] cnt0;
  logic [1:0][13:0] sampleIn;
  logic [1:0] thrCross;
  pic_psa_cfg_s [1:0] psaCfg = '0;
  pic_win_cfg_s [1:0] winCfg = {2{15'h3, 15'h2}};
  logic [14:0] coincGate = 15'h4;
  logic [14:0] antiGate = 15'h5;
  pic_rec_s [1:0] rec;
  logic coinOut;
  logic antiOut;
  int mismatches = 0;
  int cmp_count = 0;
  always #12.5 core_clk = ~core_clk;
  pic_wave_src u_src0 (.core_clk(core_clk), .rst(rst), .negPol(negPol), .trigAt(trig0),
    .cnt(cnt0), .sample(sampleIn[0]), .thr(thrCross[0]));
  pic_wave_src u_src1 (.core_clk(core_clk), .rst(rst), .negPol(negPol), .trigAt(trig1),
    .cnt(), .sample(sampleIn[1]), .thr(thrCross[1]));
  pic_core #(.NCH(2), .SAMPLE_W(14), .WIN_MAX_CYC(64)) u_dut (.core_clk(core_clk), .rst(rst),
    .sampleIn(sampleIn), .thrCross(thrCross), .psaCfg(psaCfg), .winCfg(winCfg),
    .coincGateCyc(coincGate), .antiGateCyc(antiGate), .pulseShapeIntegrals(rec),
    .coincidenceOut(coinOut), .anticoincidenceOut(antiOut));
  // Ramp sum over a window, scaled by a right shift and clipped to the field
  function automatic logic [15:0] expSum(int first, int n, logic [3:0] f);
    longint s = 0;
    for (int k = first; k < first + n; k++)
      s += k % 16384;
    s = s >> f;
    return (s > 65535) ? 16'hFFFF : s[15:0];
  endfunction
  task automatic finish_test();
    $display("mismatches=%0d comparisons=%0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // One pulse on both channels with the given settings; sums judged on both records
  task automatic run_psa(pic_psa_cfg_s c);
    int t0;
    int w;
    logic [15:0] eRise;
    logic [15:0] eFall;
    logic [15:0] eTotal;
    @(posedge core_clk);
    psaCfg <= {c, c};
    negPol <= c.negPol;
    t0 = int'(cnt0) + 600;
    trig0 <= t0;
    trig1 <= t0;
    eRise = expSum(t0 - c.riseStart, c.riseLen, c.sumReductionFactor);
    eFall = expSum(t0 + c.fallStart, c.fallStop - c.fallStart + 1, c.sumReductionFactor);
    eTotal = expSum(t0 - c.totalStart, c.totalLen, c.sumReductionFactor);
    for (w = 0; w < 20000 && rec[0].valid !== 1'b1; w++)
      @(posedge core_clk);
    for (int ch = 0; ch < 2; ch++)
    begin
      `CHK(rec[ch].valid, 1'b1)
      `CHK(rec[ch].rise, eRise)
      `CHK(rec[ch].fall, eFall)
      `CHK(rec[ch].total, eTotal)
    end
  endtask
  // Channel 1 follows channel 0 after gap cycles, or stays idle when gap is negative
  task automatic run_coincidence_out(int gap, int expC, int expA);
    int t0;
    int nC = 0;
    int nA = 0;
    @(posedge core_clk);
    t0 = int'(cnt0) + 4;
    trig0 <= t0;
    trig1 <= (gap < 0) ? 32'hFFFFFFFF : 32'(t0 + gap);
    repeat (60)
    begin
      @(posedge core_clk);
      nC += (coinOut === 1'b1);
      nA += (antiOut === 1'b1);
    end
    `CHK(nC, expC)
    `CHK(nA, expA)
  endtask
  // Main sequence: reset, three pulse shapes, then gate widths in two settings
  initial
  begin
    repeat (6) @(posedge core_clk);
    rst <= 1'h0;
    // Every case keeps fall stop above fall start
    // Cases one and two pick factors that keep each sum within 16 bits
    // The third case overruns on purpose so the clipped full-scale field is seen
    run_psa('{1'h0, 9'h5, 14'h8, 14'h5, 14'h19, 9'h5, 14'h32, 4'h0});
    run_psa('{1'h1, 9'h1F2, 14'h3FFF, 14'h1, 14'h3FFF, 9'h1, 14'h3FFF, 4'hF});
    run_psa('{1'h0, 9'h1, 14'h1, 14'h1, 14'h2, 9'h1, 14'h200, 4'h0});
    for (int i = 0; i < 2; i++)
    begin
      coincGate <= 15'(4 + 5 * i);
      antiGate <= 15'(5 + 4 * i);
      winCfg[0].antiTime <= 15'(2 + 6 * i);
      run_coincidence_out(0, 4 + 5 * i, 0);
      run_coincidence_out(-1, 0, 5 + 4 * i);
      run_coincidence_out(2, 4 + 5 * i, 5 + 4 * i);
    end
    // Windows of three cycles no longer overlap at a gap of three
    run_coincidence_out(3, 0, 9);
    finish_test();
  end
  // Watchdog well beyond the longest pulse of about 17000 cycles
  initial
  begin
    #(25 * 80000);
    mismatches++;
    finish_test();
  end
endmodule
bind pic_core pic_core_sva #(.NCH(NCH), .SAMPLE_W(SAMPLE_W), .WIN_MAX_CYC(WIN_MAX_CYC)) u_sva (
  .core_clk(core_clk), .rst(rst), .sampleIn(sampleIn), .thrCross(thrCross), .psaCfg(psaCfg),
  .winCfg(winCfg), .coincGateCyc(coincGateCyc), .antiGateCyc(antiGateCyc),
  .pulseShapeIntegrals(pulseShapeIntegrals), .coincidenceOut(coincidenceOut),
  .anticoincidenceOut(anticoincidenceOut));

// *** hw/pic_core.sv ***
// Pulse integral and coincidence core: three windowed sums per pulse, coincidence outputs.
// Assumes samples and crossing pulses come from logic on core_clk, one sample per clock.
//
// Behaviour
// - Negative-polarity samples are inverted so every sum sees a positive pulse.
// - Rising window start is 1 to 498 samples before the crossing sample.
// - Rising window length is 1 to 16383 samples from its start.
// - Rising sum starts start-count samples before crossing, runs length samples.
// - Falling window start and stop are each 1 to 16383 samples.
// - Falling sum covers samples start to stop after the crossing, both included.
// - Whole-pulse start is 1 to 498 samples back from the crossing.
// - Whole-pulse length is 1 to 16383 samples from its start.
// - Each sum is scaled by the reduction factor into rise, fall, total fields.
// - Each channel holds a coincidence window, 16 ns to 524 us, after its signal.
// - All channel windows active together drive the coincidence gate output.
// - A lone channel signal with none from others drives the anticoincidence gate.
// - Each channel has its own anticoincidence window, 16 ns to 524 us.
// - Anticoincidence gate holds 120 ns to 524 us after detection.
module pic_core #(
  parameter int NCH = pic_pkg::NCH_DEF,
  parameter int SAMPLE_W = pic_pkg::SAMPLE_W_DEF,
  parameter int WIN_MAX_CYC = pic_pkg::WIN_MAX_CYC
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [NCH-1:0][SAMPLE_W-1:0] sampleIn,
  input wire logic [NCH-1:0] thrCross,
  input wire pic_pkg::pic_psa_cfg_s [NCH-1:0] psaCfg,
  input wire pic_pkg::pic_win_cfg_s [NCH-1:0] winCfg,
  input wire logic [pic_pkg::TIME_W-1:0] coincGateCyc,
  input wire logic [pic_pkg::TIME_W-1:0] antiGateCyc,
  output wire pic_pkg::pic_rec_s [NCH-1:0] pulseShapeIntegrals,
  output logic coincidenceOut,
  output logic anticoincidenceOut
);
  import pic_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Shift-based reduction; saturates so an oversized sum never wraps
  function automatic logic [OUT_W-1:0] scaleSum(input logic [SUM_W-1:0] s,
                                                input logic [3:0] sh);
    logic [SUM_W-1:0] q;
    q = s >> sh;
    scaleSum = (q > SUM_W'(OUT_MAX)) ? OUT_MAX : q[OUT_W-1:0];
  endfunction

  // Forces a cycle count into the legal range of its setting
  function automatic logic [TIME_W-1:0] clampCyc(input logic [TIME_W-1:0] v,
                                                 input logic [TIME_W-1:0] lo,
                                                 input logic [TIME_W-1:0] hi);
    if (v < lo)
      clampCyc = lo;
    else if (v > hi)
      clampCyc = hi;
    else
      clampCyc = v;
  endfunction

  localparam logic [TIME_W-1:0] WMIN = TIME_W'(WIN_MIN_CYC);
  localparam logic [TIME_W-1:0] WMAX = TIME_W'(WIN_MAX_CYC);

  wire [NCH-1:0] coincAct;
  wire [NCH-1:0] antiHit;

  // ----------------------------------------------------------------
  // Per-channel integration and windows
  // ----------------------------------------------------------------
  for (genvar c = 0; c < NCH; c++)
  begin : g_ch
    logic [SUM_W-1:0] hist [HIST_DEPTH];
    logic [SUM_W-1:0] acc_r, acc_nxt;
    logic [HIST_AW-1:0] wrPtr_r, wrPtr_nxt;
    logic busy_r, busy_nxt;
    logic [OFF_W-1:0] k_r, k_nxt;
    logic [SUM_W-1:0] pt_r [NPT];
    logic [SUM_W-1:0] pt_nxt [NPT];
    logic signed [OFF_W-1:0] off [NPT];
    logic signed [OFF_W-1:0] lastOff;
    logic [SAMPLE_W-1:0] pos;
    pic_rec_s rec_r, rec_nxt;
    logic [TIME_W-1:0] cWin_r, cWin_nxt, aWin_r, aWin_nxt;
    logic seen_r, seen_nxt, otherTrig;
    logic [NCH-1:0] ownMask;

    // Running prefix sum; a window sum is the difference of two captured prefixes,
    // so past starts come from the history and future ends are caught as they pass
    always_comb
    begin
      pos = psaCfg[c].negPol ? ~sampleIn[c] : sampleIn[c];
      acc_nxt = acc_r + SUM_W'(pos);
      wrPtr_nxt = wrPtr_r + HIST_AW'(1);
      // Window edges relative to the crossing sample, end exclusive
      off[0] = -$signed({7'h00, psaCfg[c].riseStart});
      off[1] = off[0] + $signed({2'h0, psaCfg[c].riseLen});
      off[2] = $signed({2'h0, psaCfg[c].fallStart});
      off[3] = $signed({2'h0, psaCfg[c].fallStop}) + 16'sh0001;
      off[4] = -$signed({7'h00, psaCfg[c].totalStart});
      off[5] = off[4] + $signed({2'h0, psaCfg[c].totalLen});
      lastOff = off[3];
      if (off[1] > lastOff)
        lastOff = off[1];
      if (off[5] > lastOff)
        lastOff = off[5];
      busy_nxt = busy_r;
      k_nxt = k_r;
      pt_nxt = pt_r;
      rec_nxt = rec_r;
      rec_nxt.valid = 1'b0;
      if (!busy_r && thrCross[c])
      begin
        busy_nxt = 1'b1;
        k_nxt = OFF_W'(1);
        for (int p = 0; p < NPT; p++)
        begin
          if (off[p] == 16'sh0000)
            pt_nxt[p] = acc_r;
          else if (off[p] < 16'sh0000)
            pt_nxt[p] = hist[wrPtr_r + off[p][HIST_AW-1:0]];
        end
      end
      else if (busy_r)
      begin
        for (int p = 0; p < NPT; p++)
        begin
          if ($signed(k_r) == off[p])
            pt_nxt[p] = acc_r;
        end
        if ($signed(k_r) == lastOff)
        begin
          busy_nxt = 1'b0;
          rec_nxt.valid = 1'b1;
          rec_nxt.rise = scaleSum(pt_nxt[1] - pt_nxt[0],
                                  psaCfg[c].sumReductionFactor);
          rec_nxt.fall = scaleSum(pt_nxt[3] - pt_nxt[2],
                                  psaCfg[c].sumReductionFactor);
          rec_nxt.total = scaleSum(pt_nxt[5] - pt_nxt[4],
                                   psaCfg[c].sumReductionFactor);
        end
        else
          k_nxt = k_r + OFF_W'(1);
      end
    end

    // Coincidence and anticoincidence windows of this channel
    always_comb
    begin
      ownMask = '1;
      ownMask[c] = 1'b0;
      otherTrig = |(thrCross & ownMask);
      if (thrCross[c])
        cWin_nxt = clampCyc(winCfg[c].coincTime, WMIN, WMAX);
      else
        cWin_nxt = (cWin_r != '0) ? cWin_r - TIME_W'(1) : cWin_r;
      aWin_nxt = aWin_r;
      seen_nxt = seen_r;
      if (aWin_r == '0)
      begin
        if (thrCross[c])
        begin
          aWin_nxt = clampCyc(winCfg[c].antiTime, WMIN, WMAX);
          seen_nxt = otherTrig;
        end
      end
      else
      begin
        aWin_nxt = aWin_r - TIME_W'(1);
        seen_nxt = seen_r | otherTrig;
      end
    end

    assign coincAct[c] = (cWin_r != '0);
    assign antiHit[c] = (aWin_r == TIME_W'(1)) && !seen_nxt;
    assign pulseShapeIntegrals[c] = rec_r;

    // History holds one prefix per sample; no reset, it is overwritten before use
    always_ff @(posedge core_clk)
    begin
      hist[wrPtr_r] <= acc_r;
    end

    // Channel state registers
    always_ff @(posedge core_clk or posedge rst)
    begin
      if (rst)
      begin
        acc_r <= '0;
        wrPtr_r <= '0;
        busy_r <= 1'b0;
        k_r <= '0;
        for (int p = 0; p < NPT; p++)
          pt_r[p] <= '0;
        rec_r <= '0;
        cWin_r <= '0;
        aWin_r <= '0;
        seen_r <= 1'b0;
      end
      else
      begin
        acc_r <= acc_nxt;
        wrPtr_r <= wrPtr_nxt;
        busy_r <= busy_nxt;
        k_r <= k_nxt;
        for (int p = 0; p < NPT; p++)
          pt_r[p] <= pt_nxt[p];
        rec_r <= rec_nxt;
        cWin_r <= cWin_nxt;
        aWin_r <= aWin_nxt;
        seen_r <= seen_nxt;
      end
    end
  end

  // ----------------------------------------------------------------
  // Output gates
  // ----------------------------------------------------------------
  logic allAct_r, allAct_nxt;
  logic [TIME_W-1:0] cGate_r, cGate_nxt, aGate_r, aGate_nxt;
  logic coincOut_nxt, antiOut_nxt;

  // Gates start on the first cycle all windows overlap, or on a lone expiry
  always_comb
  begin
    allAct_nxt = &coincAct;
    if (allAct_nxt && !allAct_r)
      cGate_nxt = clampCyc(coincGateCyc, TIME_W'(CGATE_MIN_CYC), WMAX);
    else
      cGate_nxt = (cGate_r != '0) ? cGate_r - TIME_W'(1) : cGate_r;
    if (|antiHit)
      aGate_nxt = clampCyc(antiGateCyc, TIME_W'(AGATE_MIN_CYC), WMAX);
    else
      aGate_nxt = (aGate_r != '0) ? aGate_r - TIME_W'(1) : aGate_r;
    coincOut_nxt = (cGate_nxt != '0);
    antiOut_nxt = (aGate_nxt != '0);
  end

  // Gate registers; outputs come straight from flops
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      allAct_r <= 1'b0;
      cGate_r <= '0;
      aGate_r <= '0;
      coincidenceOut <= 1'b0;
      anticoincidenceOut <= 1'b0;
    end
    else
    begin
      allAct_r <= allAct_nxt;
      cGate_r <= cGate_nxt;
      aGate_r <= aGate_nxt;
      coincidenceOut <= coincOut_nxt;
      anticoincidenceOut <= antiOut_nxt;
    end
  end

endmodule

// *** pkg/pic_pkg.sv ***
// Package for the pulse integral and coincidence block: widths, limits, timing, carriers.
// Assumes one core_clk at 40 MHz, with one waveform sample delivered per clock.
package pic_pkg;

  // ----------------------------------------------------------------
  // Widths and sizes
  // ----------------------------------------------------------------
  localparam int NCH_DEF = 4;
  localparam int SAMPLE_W_DEF = 14;
  localparam int SUM_W = 32;
  localparam int OUT_W = 16;
  localparam int HIST_AW = 9;
  localparam int HIST_DEPTH = 512;
  localparam int OFF_W = 16;
  localparam int NPT = 6;
  localparam int TIME_W = 15;
  localparam logic [OUT_W-1:0] OUT_MAX = 16'hFFFF;

  // ----------------------------------------------------------------
  // Setting ranges, in samples
  // ----------------------------------------------------------------
  localparam int PRE_MIN = 1;
  localparam int PRE_MAX = 498;
  localparam int LEN_MAX = 16383;

  // ----------------------------------------------------------------
  // Timing: figures in ns, counts derived from the clock period
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int WIN_MIN_NS = 16;
  localparam int WIN_MAX_NS = 524000;
  localparam int AGATE_MIN_NS = 120;
  localparam int CGATE_MIN_NS = 16;
  // Least times round up, longest times round down
  localparam int WIN_MIN_CYC = (WIN_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WIN_MAX_CYC = WIN_MAX_NS / CLK_PERIOD_NS;
  localparam int AGATE_MIN_CYC = (AGATE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CGATE_MIN_CYC = (CGATE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  // Per-channel integration settings
  typedef struct packed {
    logic negPol;
    logic [8:0] riseStart;
    logic [13:0] riseLen;
    logic [13:0] fallStart;
    logic [13:0] fallStop;
    logic [8:0] totalStart;
    logic [13:0] totalLen;
    logic [3:0] sumReductionFactor;
  } pic_psa_cfg_s;

  // Per-channel window times, in clock cycles
  typedef struct packed {
    logic [TIME_W-1:0] coincTime;
    logic [TIME_W-1:0] antiTime;
  } pic_win_cfg_s;

  // One event record of scaled sums
  typedef struct packed {
    logic valid;
    logic [OUT_W-1:0] rise;
    logic [OUT_W-1:0] fall;
    logic [OUT_W-1:0] total;
  } pic_rec_s;

endpackage
